// ### hdl/hpe_pkg.sv
// Package: register map, field layout and carriers for the hose error block
package hpe_pkg;

	// Register offsets (the flag summary register has no printed offset)
	localparam logic [11:0] OFS_FAIL_ADDR = 12'h200;
	localparam logic [11:0] OFS_IMASK     = 12'h280;
	localparam logic [11:0] OFS_DIAG      = 12'h300;
	localparam logic [11:0] OFS_PEND      = 12'h380;
	localparam logic [11:0] OFS_ERR       = 12'h180;

	// Error flag positions
	localparam int ERR_SUM     = 0;
	localparam int ERR_MB_LEN  = 1;
	localparam int ERR_MB_PAR  = 2;
	localparam int ERR_CSR_OVR = 3;
	localparam int ERR_CSR_PAR = 4;
	localparam int ERR_DISC_MA = 5;
	localparam int ERR_RD_RET  = 6;
	localparam int ERR_MAP_PAR = 7;
	localparam int ERR_W       = 8;

	// Interrupt enable and priority fields
	localparam int IM_ERR_EN  = 16;
	localparam int IM_DEV_LO  = 17;
	localparam int IM_ERR_LO  = 21;
	localparam int IM_W       = 25;
	localparam int NUM_LINES  = 16;

	// Diagnostic fields
	localparam int DG_PCI_LO   = 0;
	localparam int DG_UP_BAD   = 2;
	localparam int DG_REV_LO   = 3;
	localparam int DG_INV_DOWN = 7;
	localparam int DG_W        = 8;

	// Pending register error bit
	localparam int PD_ERR = 16;

	// Failing address fields
	localparam int FA_DIR = 0;

	// Revision identifier (value is arbitrary)
	localparam logic [3:0] REV_ID = 4'h5;

	localparam logic [31:0] RST_ZERO = 32'h0000_0000;

	// PCI parity force codes
	localparam logic [1:0] PCI_PAR_OK   = 2'h0;
	localparam logic [1:0] PCI_PAR_ADDR = 2'h1;
	localparam logic [1:0] PCI_PAR_DATA = 2'h2;

	// Register access request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [31:0] wdata;
	} hpe_reg_req_s;

	// Error events from the hose and PCI datapaths, one-cycle pulses
	typedef struct packed {
		logic        map_par;
		logic        rd_ret;
		logic        disc_ma;
		logic        csr_par;
		logic        csr_ovr;
		logic        mb_par;
		logic        mb_len;
		logic [29:0] dma_addr;
		logic        dma_write;
	} hpe_err_ev_s;

	// Interrupt send state machine states
	typedef enum logic [1:0] {
		HPE_IDLE = 2'b00,
		HPE_SEND = 2'b01
	} hpe_snd_e;

endpackage

// ### hdl/hpe_top.sv
// Error capture, interrupt mask, pending sampling and parity diagnostics
//
// Function
// - map RAM parity sets bit seven, captures address
// - bad read-return packet sets bit six
// - disconnected master abort sets bit five
// - CSR packet parity bit four, overrun bit three
// - mailbox parity bit two, bad length bit one
// - summary bit zero; flags reset zero, W1C
// - DMA error latches PCI address bits 31:2
// - failing address bit zero records direction
// - error interrupt only while enable bit set
// - slot lines recognised only where enabled
// - one-hot error priority field selects level
// - one-hot device priority field, same encoding
// - invert down-hose parity check, self clearing
// - force bad parity on up-hose data
// - PCI parity corruption from diagnostic code
// - read-only revision in diagnostic bits 6:3
// - pending shows unsent requests; write resamples in level mode only
// - edge mode earlier variant, level mode later
// - error interrupt only on first flag set
`timescale 1ns/100ps
module hpe_top
(
	// Clock, reset, enable
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic                  clk_en,
	// Variant: high selects level-sensitive device interrupts
	input  wire logic                  level_mode,
	// Register access from the hose command decoder
	input  wire hpe_pkg::hpe_reg_req_s reg_req,
	output logic [31:0]                reg_rdata,
	output logic                       reg_rvalid,
	// Error events from the datapaths
	input  wire hpe_pkg::hpe_err_ev_s  err_ev,
	// Down-hose check of the fourth cycle of mailbox and CSR writes
	input  wire logic                  down_chk_valid,
	input  wire logic                  down_par_bad,
	output logic                       down_par_err,
	// Slot interrupt lines, slot s line A..D at 4*s..4*s+3
	input  wire logic [15:0]           slot_int_req,
	// Interrupt request toward the hose, one transaction at a time
	output logic                       intr_req,
	output logic                       intr_is_err,
	output logic [3:0]                 intr_level,
	output logic [3:0]                 intr_src,
	input  wire logic                  intr_ack,
	input  wire logic                  intr_done,
	// Parity controls to the up-hose and PCI datapaths
	output logic                       up_force_bad,
	output logic                       pci_bad_addr,
	output logic                       pci_bad_data
);

	logic [hpe_pkg::ERR_W-1:0]     err_flags;
	logic [31:0]                   fail_addr;
	logic [hpe_pkg::IM_W-1:0]      imask;
	logic [hpe_pkg::DG_W-1:0]      diag;
	logic [hpe_pkg::NUM_LINES:0]   pend;
	logic [15:0]                   line_s1;
	logic [15:0]                   line_s2;
	logic [15:0]                   line_d;
	logic                          err_any_d;
	hpe_pkg::hpe_snd_e             snd_st;
	logic                          snd_err;
	logic [3:0]                    snd_src;

	// Slot inputs are asynchronous pins
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			line_s1 <= 16'h0000;
			line_s2 <= 16'h0000;
		end
		else if (clk_en)
		begin
			line_s1 <= slot_int_req;
			line_s2 <= line_s1;
		end
	end

	// Address decode
	wire sel_err  = reg_req.addr == hpe_pkg::OFS_ERR;
	wire sel_fa   = reg_req.addr == hpe_pkg::OFS_FAIL_ADDR;
	wire sel_im   = reg_req.addr == hpe_pkg::OFS_IMASK;
	wire sel_dg   = reg_req.addr == hpe_pkg::OFS_DIAG;
	wire sel_pd   = reg_req.addr == hpe_pkg::OFS_PEND;
	wire wr_err   = reg_req.wr && sel_err;
	wire wr_im    = reg_req.wr && sel_im;
	wire wr_dg    = reg_req.wr && sel_dg;
	wire wr_pd    = reg_req.wr && sel_pd;

	// Incoming error events gathered at their flag positions
	wire [hpe_pkg::ERR_W-1:0] ev_vec = {
		err_ev.map_par, err_ev.rd_ret, err_ev.disc_ma, err_ev.csr_par,
		err_ev.csr_ovr, err_ev.mb_par, err_ev.mb_len, 1'b0};
	wire dma_err = err_ev.map_par || err_ev.rd_ret;
	wire [31:0] fa_word = {err_ev.dma_addr, 1'b0, err_ev.dma_write};
	wire inv_par_err = down_chk_valid &&
		(down_par_bad ^ diag[hpe_pkg::DG_INV_DOWN]);

	// sticky flags, set wins over clear
	wire [hpe_pkg::ERR_W-1:0] clr_mask =
		wr_err ? reg_req.wdata[hpe_pkg::ERR_W-1:0] : '0;
	wire [hpe_pkg::ERR_W-1:0] kept = (err_flags & ~clr_mask) | ev_vec;
	wire [hpe_pkg::ERR_W-1:0] next_err_flags =
		{kept[hpe_pkg::ERR_W-1:1], |kept[hpe_pkg::ERR_W-1:1]};
	wire err_any = err_flags[hpe_pkg::ERR_SUM];

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			err_flags <= '0;
		else if (clk_en)
			err_flags <= next_err_flags;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			fail_addr <= hpe_pkg::RST_ZERO;
		else if (clk_en && dma_err)
			fail_addr <= fa_word;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			imask <= '0;
		else if (clk_en && wr_im)
			imask <= reg_req.wdata[hpe_pkg::IM_W-1:0];
	end

	// self-clearing inversion after a detected parity error
	wire [hpe_pkg::DG_W-1:0] dg_wval = {reg_req.wdata[hpe_pkg::DG_INV_DOWN],
		hpe_pkg::REV_ID, reg_req.wdata[hpe_pkg::DG_UP_BAD:0]};
	wire [hpe_pkg::DG_W-1:0] next_diag = wr_dg ? dg_wval :
		(inv_par_err ? {1'b0, diag[hpe_pkg::DG_W-2:0]} : diag);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			diag <= {1'b0, hpe_pkg::REV_ID, 3'h0};
		else if (clk_en)
			diag <= next_diag;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			down_par_err <= 1'b0;
		else if (clk_en)
			down_par_err <= inv_par_err;
	end

	// two-bit PCI parity code; the undefined code forces nothing
	wire [1:0] next_pci_code = next_diag[hpe_pkg::DG_PCI_LO +: 2];

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			up_force_bad <= 1'b0;
			pci_bad_addr <= 1'b0;
			pci_bad_data <= 1'b0;
		end
		else if (clk_en)
		begin
			up_force_bad <= next_diag[hpe_pkg::DG_UP_BAD];
			pci_bad_addr <= next_pci_code == hpe_pkg::PCI_PAR_ADDR;
			pci_bad_data <= next_pci_code == hpe_pkg::PCI_PAR_DATA;
		end
	end

	// Previous line and error levels for transition detection
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			line_d    <= 16'h0000;
			err_any_d <= 1'b0;
		end
		else if (clk_en)
		begin
			line_d    <= line_s2;
			err_any_d <= err_any;
		end
	end

	// Line in progress is excluded from resampling
	wire dev_busy = snd_st == hpe_pkg::HPE_SEND && !snd_err;
	wire err_busy = snd_st == hpe_pkg::HPE_SEND && snd_err;
	wire take     = snd_st == hpe_pkg::HPE_IDLE && intr_ack == 1'b0;

	// Lowest pending line wins; errors first
	logic [3:0] pick_src;
	always_comb
	begin
		pick_src = 4'h0;
		for (int i = hpe_pkg::NUM_LINES - 1; i >= 0; i--)
			if (pend[i])
				pick_src = 4'(i);
	end
	wire pick_err = pend[hpe_pkg::PD_ERR];
	wire fire     = take && (pick_err || |pend[hpe_pkg::NUM_LINES-1:0]);

	logic [hpe_pkg::NUM_LINES-1:0] next_pend_dev;
	genvar g;
	generate
		for (g = 0; g < hpe_pkg::NUM_LINES; g++)
		begin : g_line
			wire in_prog = dev_busy && snd_src == 4'(g);
			wire edge_ev = line_s2[g] && !line_d[g];
			wire resamp  = wr_pd && level_mode && line_s2[g] && !in_prog;
			wire sent    = snd_st == hpe_pkg::HPE_IDLE && fire && !pick_err
				&& pick_src == 4'(g);
			assign next_pend_dev[g] = imask[g] &&
				(edge_ev || resamp || (pend[g] && !sent));
		end
	endgenerate

	// error request only on first flag after all cleared
	wire err_first = err_any && !err_any_d;
	// error interrupt gated by its enable
	wire err_req = imask[hpe_pkg::IM_ERR_EN] &&
		(err_first || (pend[hpe_pkg::PD_ERR] && !err_busy));

	wire [hpe_pkg::NUM_LINES:0] next_pend = {
		err_req && !(take && fire && pick_err), next_pend_dev};

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			pend <= '0;
		else if (clk_en)
			pend <= next_pend;
	end

	// level field chosen by source type
	wire [3:0] err_lvl = imask[hpe_pkg::IM_ERR_LO +: 4];
	wire [3:0] dev_lvl = imask[hpe_pkg::IM_DEV_LO +: 4];
	wire [3:0] pick_lvl = pick_err ? err_lvl : dev_lvl;

	// Request lifetime: raised on a pick, dropped on acknowledge
	wire go_send       = snd_st == hpe_pkg::HPE_IDLE && fire;
	wire got_ack       = snd_st == hpe_pkg::HPE_SEND && intr_ack;
	wire next_intr_req = go_send || (intr_req && !got_ack);

	hpe_pkg::hpe_snd_e next_snd_st;
	always_comb
	begin
		case (snd_st)
			hpe_pkg::HPE_IDLE:
				if (fire)
					next_snd_st = hpe_pkg::HPE_SEND;
				else
					next_snd_st = hpe_pkg::HPE_IDLE;
			hpe_pkg::HPE_SEND:
				if (intr_done)
					next_snd_st = hpe_pkg::HPE_IDLE;
				else
					next_snd_st = hpe_pkg::HPE_SEND;
			default:
				next_snd_st = hpe_pkg::HPE_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			snd_st   <= hpe_pkg::HPE_IDLE;
			intr_req <= 1'b0;
		end
		else if (clk_en)
		begin
			snd_st   <= next_snd_st;
			intr_req <= next_intr_req;
		end
	end

	// Source fields latched when a request is picked
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			snd_err     <= 1'b0;
			snd_src     <= 4'h0;
			intr_is_err <= 1'b0;
			intr_level  <= 4'h0;
			intr_src    <= 4'h0;
		end
		else if (clk_en && go_send)
		begin
			snd_err     <= pick_err;
			snd_src     <= pick_src;
			intr_is_err <= pick_err;
			intr_level  <= pick_lvl;
			intr_src    <= pick_src;
		end
	end

	// Read words, reserved bits read as zero
	wire [31:0] rw_err = {24'h0, err_flags};
	wire [31:0] rw_im  = {7'h0, imask};
	wire [31:0] rw_dg  = {24'h0, diag};
	wire [31:0] rw_pd  = {15'h0, pend};

	// Read data mux
	wire [31:0] rd_mux =
		sel_err ? rw_err :
		sel_fa  ? fail_addr :
		sel_im  ? rw_im :
		sel_dg  ? rw_dg :
		sel_pd  ? rw_pd : hpe_pkg::RST_ZERO;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata  <= hpe_pkg::RST_ZERO;
			reg_rvalid <= 1'b0;
		end
		else if (clk_en)
		begin
			reg_rdata  <= reg_req.rd ? rd_mux : hpe_pkg::RST_ZERO;
			reg_rvalid <= reg_req.rd;
		end
	end

endmodule

// ### tb/hpe_top_asserts.sv
// Checker: port timing relations of the hose error block
`timescale 1ns/100ps
module hpe_top_asserts
(
	// Clock and reset
	input wire logic			sys_clk,
	input wire logic			rst_n,
	input wire logic			clk_en,
	// Register access
	input wire hpe_pkg::hpe_reg_req_s	reg_req,
	input wire logic [31:0]			reg_rdata,
	input wire logic			reg_rvalid,
	// Parity and interrupts
	input wire logic			down_chk_valid,
	input wire logic			down_par_err,
	input wire logic			intr_req,
	input wire logic			intr_is_err,
	input wire logic [3:0]			intr_level,
	input wire logic [3:0]			intr_src,
	input wire logic			intr_ack,
	input wire logic			up_force_bad,
	input wire logic			pci_bad_addr,
	input wire logic			pci_bad_data
);
	logic [31:0]	mask_s;
	wire		wr_ok = clk_en && reg_req.wr;
	wire		diag_wr = wr_ok && reg_req.addr == hpe_pkg::OFS_DIAG;

	// Shadow of the mask register
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			mask_s <= '0;
		else if (wr_ok && reg_req.addr == hpe_pkg::OFS_IMASK)
			mask_s <= reg_req.wdata;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_read(a);
		reg_req.rd && clk_en && reg_req.addr == a;
	endsequence
	sequence s_ack;
		intr_req && intr_ack;
	endsequence

	a_rev_read:
	assert property (s_read(hpe_pkg::OFS_DIAG) |=> reg_rvalid
		&& reg_rdata[6:3] == hpe_pkg::REV_ID) else $error("bad revision");
	a_summary_bit:
	assert property (s_read(hpe_pkg::OFS_ERR) |=>
		reg_rdata[0] == |reg_rdata[7:1]) else $error("bad summary");
	a_err_enabled:
	assert property ($rose(intr_req) && intr_is_err |-> mask_s[16])
		else $error("error interrupt while disabled");
	a_err_level:
	assert property (intr_req && intr_is_err |-> intr_level ==
		mask_s[24:21]) else $error("bad error level");
	a_dev_level:
	assert property (intr_req && !intr_is_err |-> intr_level ==
		mask_s[20:17]) else $error("bad device level");
	a_line_enabled:
	assert property ($rose(intr_req) && !intr_is_err |-> mask_s[intr_src])
		else $error("masked line sent");
	a_req_holds:
	assert property (intr_req && !intr_ack |=> intr_req)
		else $error("request dropped early");
	a_ack_drops:
	assert property (s_ack |=> !intr_req) else $error("request after ack");
	a_down_cause:
	assert property (down_par_err |-> $past(down_chk_valid))
		else $error("parity error without check");
	a_up_bad:
	assert property (diag_wr |-> ##2 up_force_bad ==
		$past(reg_req.wdata[2], 2)) else $error("bad up parity force");
	a_pci_bad:
	assert property (diag_wr |-> ##2 {pci_bad_data, pci_bad_addr} ==
		$past(reg_req.wdata[1:0], 2)) else $error("bad pci parity force");
endmodule

bind hpe_top hpe_top_asserts hpe_top_asserts_inst (.sys_clk, .rst_n,
	.clk_en, .reg_req, .reg_rdata, .reg_rvalid, .down_chk_valid,
	.down_par_err, .intr_req, .intr_is_err, .intr_level, .intr_src,
	.intr_ack, .up_force_bad, .pci_bad_addr, .pci_bad_data);

// ### tb/hpe_hose_model.sv
// Hose port model: acknowledges and completes interrupt requests
`timescale 1ns/100ps
module hpe_hose_model
(
	// Clock and pacing
	input wire logic	sys_clk,
	input wire logic	slow,
	// Interrupt handshake
	input wire logic	intr_req,
	output logic		intr_ack,
	output logic		intr_done
);
	// Non-blocking drive keeps readers at the same edge race free
	initial
	begin
		intr_ack = 1'b0;
		intr_done = 1'b0;
		forever
		begin
			@(negedge sys_clk);
			if (intr_req)
			begin
				repeat (slow ? 6 : 1) @(negedge sys_clk);
				intr_ack <= 1'b1;
				@(negedge sys_clk);
				intr_ack <= 1'b0;
				repeat (slow ? 5 : 1) @(negedge sys_clk);
				intr_done <= 1'b1;
				@(negedge sys_clk);
				intr_done <= 1'b0;
			end
		end
	end
endmodule

// ### tb/tb_top.sv
// Testbench: registers, error flags, interrupts and parity controls
`timescale 1ns/100ps
module tb_top;
	localparam logic [11:0] ERR = hpe_pkg::OFS_ERR;
	localparam logic [11:0] FAD = hpe_pkg::OFS_FAIL_ADDR;
	localparam logic [11:0] MSK = hpe_pkg::OFS_IMASK;
	localparam logic [11:0] DG = hpe_pkg::OFS_DIAG;
	localparam logic [3:0] REV = hpe_pkg::REV_ID;
	logic sys_clk = 1'b0, rst_n = 1'b0, lvl = 1'b0, slow = 1'b0;
	logic chk_v = 1'b0, par_bad = 1'b0, en = 1'b1;
	logic [15:0] lines = '0;
	hpe_pkg::hpe_reg_req_s req = '0;
	hpe_pkg::hpe_err_ev_s ev = '0;
	logic [31:0] rdat, a, v;
	logic rv, perr, ireq, iack, idone, is_err, upb, pba, pbd;
	logic [3:0] ilvl, isrc;
	int mismatches = 0, checks = 0, seed = 68038, err_m = 0, k, l;
	always #2 sys_clk = ~sys_clk;
	hpe_top hpe_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(en),
		.level_mode(lvl), .reg_req(req), .reg_rdata(rdat), .reg_rvalid(rv),
		.err_ev(ev), .down_chk_valid(chk_v), .down_par_bad(par_bad),
		.down_par_err(perr), .slot_int_req(lines), .intr_req(ireq),
		.intr_is_err(is_err), .intr_level(ilvl), .intr_src(isrc),
		.intr_ack(iack), .intr_done(idone), .up_force_bad(upb),
		.pci_bad_addr(pba), .pci_bad_data(pbd));
	hpe_hose_model hpe_hose_model_inst (.sys_clk(sys_clk), .slow(slow),
		.intr_req(ireq), .intr_ack(iack), .intr_done(idone));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		@(negedge sys_clk);
		req = '{1'b0, 1'b1, ad, d};
		@(negedge sys_clk);
		req = '0;
		if (ad == ERR)
			err_m = err_m & ~d;
		if ((err_m & 'hfe) == 0)
			err_m = 0;
	endtask
	task automatic rd(input logic [11:0] ad, input logic [31:0] e);
		@(negedge sys_clk);
		req = '{1'b1, 1'b0, ad, 32'h0};
		@(negedge sys_clk);
		req = '0;
		chk(rdat, e);
		chk(32'(rv), 32'h1);
	endtask
	task automatic pulse(input int n);
		a = $random(seed);
		@(negedge sys_clk);
		ev = '0;
		ev[30 + n] = 1'b1;
		ev.dma_addr = a[29:0];
		ev.dma_write = a[31];
		@(negedge sys_clk);
		ev = '0;
		err_m = err_m | (1 << n) | 1;
	endtask
	task automatic no_intr();
		repeat (30)
		begin
			@(negedge sys_clk);
			chk(32'(ireq), 32'h0);
		end
	endtask
	task automatic get_intr(input logic e, input logic [3:0] lv, s);
		int i, t;
		for (i = 0; i < 99 && ireq !== 1'b1; i++)
			@(negedge sys_clk);
		t = i;
		chk(32'({is_err, ilvl}), 32'({e, lv}));
		if (!e)
			chk(32'(isrc), 32'(s));
		for (i = 0; i < 99 && idone !== 1'b1; i++)
			@(negedge sys_clk);
		if (t == 99 || i == 99)
		begin
			mismatches++;
			give_verdict();
		end
	endtask
	initial
	begin
		repeat (2) @(negedge sys_clk);
		rst_n = 1'b1;
		rd(ERR, 0);
		rd(FAD, 0);
		wr(12'h7fc, 32'hffff_ffff);
		rd(12'h7fc, 0);
		wr(MSK, 32'h0102_0020);
		pulse(3);
		no_intr();
		rd(ERR, err_m);
		wr(ERR, 32'hff);
		$display("test mask done");
		for (k = 1; k < 8; k++)
		begin
			slow = k[0];
			wr(MSK, 32'h0003_0020 | (1 << (22 + k % 3)));
			pulse(k);
			get_intr(1'b1, 4'(2 << (k % 3)), 4'h0);
			rd(ERR, err_m);
			if (k > 5)
				rd(FAD, {a[29:0], 1'b0, a[31]});
			pulse(k);
			no_intr();
			wr(ERR, 32'h0);
			rd(ERR, err_m);
			wr(ERR, 32'hff);
			rd(ERR, 0);
		end
		wr(FAD, 32'hffff_ffff);
		rd(FAD, {a[29:0], 1'b0, a[31]});
		$display("test errors done");
		lines[6] = 1'b1;
		no_intr();
		lines[5] = 1'b1;
		get_intr(1'b0, 4'h1, 4'h5);
		wr(hpe_pkg::OFS_PEND, 32'h0);
		no_intr();
		lvl = 1'b1;
		wr(hpe_pkg::OFS_PEND, 32'h0);
		get_intr(1'b0, 4'h1, 4'h5);
		lines = '0;
		lvl = 1'b0;
		for (k = 0; k < 6; k++)
		begin
			l = $unsigned($random(seed)) % 16;
			wr(MSK, 32'h0021_0000 | (1 << (18 + k % 3)) | (1 << l));
			lines[l] = 1'b1;
			get_intr(1'b0, 4'(2 << (k % 3)), l[3:0]);
			lines = '0;
			repeat (4) @(negedge sys_clk);
		end
		$display("test lines done");
		for (k = 0; k < 4; k++)
		begin
			v = (k == 3) ? 32'h7c : k;
			wr(DG, v);
			repeat (2) @(negedge sys_clk);
			chk(32'({upb, pbd, pba}), 32'(v[2:0]));
			rd(DG, {25'h0, REV, v[2:0]});
		end
		// Clock enable low freezes state: this write is lost
		en = 1'b0;
		wr(DG, 32'h0);
		en = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(32'(upb), 32'h1);
		rd(DG, {25'h0, REV, 3'h4});
		wr(DG, 32'h80);
		rd(DG, {24'h0, 1'b1, REV, 3'h0});
		chk_v = 1'b1;
		@(negedge sys_clk);
		chk_v = 1'b0;
		chk(32'(perr), 32'h1);
		rd(DG, {25'h0, REV, 3'h0});
		par_bad = 1'b1;
		chk_v = 1'b1;
		@(negedge sys_clk);
		chk_v = 1'b0;
		chk(32'(perr), 32'h1);
		wr(DG, 32'h80);
		chk_v = 1'b1;
		@(negedge sys_clk);
		chk_v = 1'b0;
		chk(32'(perr), 32'h0);
		par_bad = 1'b0;
		rd(DG, {24'h0, 1'b1, REV, 3'h0});
		$display("test diag done");
		give_verdict();
	end
endmodule
